// file: discharge_fault_protection_config.sv
// Discharge overcurrent and short-circuit protection registers and fault timers
// Behaviour
// - The overcurrent threshold setting is a one-byte item, offset 11, limited to 0x00-0x0F, default 0x0F, copied into the threshold register.
// - Writing a setting leaves the active registers alone until a full reset or power reset reloads them.
// - Each active protection register comes out of power-on reset cleared to zero before loading.
// - The overcurrent threshold register uses bits 3..0 as its code and ignores bits 7..4.
// - The differential sense voltage in discharge is compared against the selected overcurrent threshold.
// - With range select clear, overcurrent codes give 50 mV to 200 mV in 10 mV steps.
// - With range select set, overcurrent codes give 25 mV to 100 mV in 5 mV steps.
// - The overcurrent delay setting is a one-byte item, offset 12, default 0x0F, loaded into the delay register.
// - The overcurrent delay code in bits 3..0 selects 1 ms to 31 ms in 2 ms steps.
// - The short-circuit setting is a one-byte item, offset 16, loaded into the short-circuit register.
// - The short-circuit register holds the delay code in bits 7..4, the threshold in bits 2..0, bit 3 unused.
// - The short-circuit delay code selects 0 ms to 915 ms in 61 ms steps.
// - With the doubling bit set, the short-circuit delay is twice the coded value.
// - With range select clear, short-circuit codes give 100 mV to 450 mV in 50 mV steps.
// - With range select set, short-circuit codes start at 50 mV and rise 25 mV per step.
//
// Our own choices: the strobed register port and the address map.
module discharge_fault_protection_config #(
  parameter int MS_CYCLES_P = dfp_pkg::MS_CYCLES
) (
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_n_in,
  input  wire dfp_pkg::reg_req_s         reg_req_in,
  input  wire dfp_pkg::sense_pair_s      sense_in,
  output logic [dfp_pkg::DATA_W-1:0]     reg_rdata_out,
  output logic                           irq_out,
  output logic                           oc_fault_out,
  output logic                           sc_fault_out
);

  dfp_pkg::dfp_state_s q;
  dfp_pkg::dfp_state_s d;

  logic signed [dfp_pkg::SENSE_W:0] diff_mv;
  logic [dfp_pkg::THR_W-1:0]        oc_thr_mv;
  logic [dfp_pkg::THR_W-1:0]        sc_thr_mv;
  logic [3:0]                       oc_code;
  logic [3:0]                       oc_dly_code;
  logic [3:0]                       sc_dly_code;
  logic [2:0]                       sc_thr_code;
  logic [31:0]                      oc_dly_ms;
  logic [31:0]                      sc_dly_ms;
  logic [dfp_pkg::CNT_W-1:0]        oc_target;
  logic [dfp_pkg::CNT_W-1:0]        sc_target;
  logic                             oc_over;
  logic                             sc_over;
  logic                             oc_trip;
  logic                             sc_trip;
  logic                             wr_hit;
  logic [1:0]                       evt_set;
  logic [1:0]                       evt_clr;

  // Code fields taken from the active registers only
  // low nibble code
  assign oc_code     = q.overcurrent_threshold[dfp_pkg::CODE_MSB:0];
  assign oc_dly_code = q.overcurrent_delay[dfp_pkg::CODE_MSB:0];
  assign sc_dly_code = q.short_circuit_discharge_cfg[dfp_pkg::SC_DLY_MSB:dfp_pkg::SC_DLY_LSB];
  assign sc_thr_code = q.short_circuit_discharge_cfg[dfp_pkg::SC_THR_MSB:0];

  // Threshold selection in mV; range select scales both tables
  always_comb begin
    oc_thr_mv = dfp_pkg::THR_W'(dfp_pkg::OC_THR_BASE_MV + dfp_pkg::OC_THR_STEP_MV * int'(oc_code));
    sc_thr_mv = dfp_pkg::THR_W'(dfp_pkg::SC_THR_BASE_MV
                + dfp_pkg::SC_THR_STEP_MV * int'(sc_thr_code));
    if (q.sense_range_select) begin
      oc_thr_mv = dfp_pkg::THR_W'(dfp_pkg::OC_THR_BASE_LO_MV
                  + dfp_pkg::OC_THR_STEP_LO_MV * int'(oc_code));
      sc_thr_mv = dfp_pkg::THR_W'(dfp_pkg::SC_THR_BASE_LO_MV
                  + dfp_pkg::SC_THR_STEP_LO_MV * int'(sc_thr_code));
    end
  end

  // Differential voltage; only the discharge direction (positive) can trip
  // compare against threshold
  assign diff_mv = $signed({1'b0, sense_in.sense_positive}) - $signed({1'b0, sense_in.sense_negative});
  assign oc_over = (diff_mv >= $signed({3'b000, oc_thr_mv})) && (q.st == dfp_pkg::ST_RUN);
  assign sc_over = (diff_mv >= $signed({3'b000, sc_thr_mv})) && (q.st == dfp_pkg::ST_RUN);

  // Delay targets in clock cycles
  always_comb begin
    // 1 ms plus 2 ms per code
    oc_dly_ms = 32'(dfp_pkg::OC_DLY_BASE_MS + dfp_pkg::OC_DLY_STEP_MS * int'(oc_dly_code));
    sc_dly_ms = 32'(dfp_pkg::SC_DLY_STEP_MS * int'(sc_dly_code));
    if (q.short_delay_doubling) begin
      sc_dly_ms = {sc_dly_ms[30:0], 1'b0};
    end
    oc_target = dfp_pkg::CNT_W'(oc_dly_ms * 32'(MS_CYCLES_P));
    sc_target = dfp_pkg::CNT_W'(sc_dly_ms * 32'(MS_CYCLES_P));
  end

  // Qualification: the counter must reach its target with no gap in the indication
  // continuous assertion required
  assign oc_trip = oc_over && (q.oc_cnt >= oc_target) && !q.oc_held;
  assign sc_trip = sc_over && (q.sc_cnt >= sc_target) && !q.sc_held;

  // Event and clear vectors for the sticky status
  assign wr_hit  = reg_req_in.wr && (reg_req_in.addr == dfp_pkg::ADDR_STATUS);
  assign evt_set = {sc_trip, oc_trip};
  assign evt_clr = wr_hit ? reg_req_in.wdata[1:0] : 2'b00;

  // Next-state logic for the whole block
  always_comb begin
    d = q;

    // Load sequence: cleared registers first, then the settings are copied in
    case (q.st)
      dfp_pkg::ST_CLEAR: begin
        d.overcurrent_threshold       = dfp_pkg::ACTIVE_RESET;
        d.overcurrent_delay           = dfp_pkg::ACTIVE_RESET;
        d.short_circuit_discharge_cfg = dfp_pkg::ACTIVE_RESET;
        d.st                          = dfp_pkg::ST_LOAD;
      end
      dfp_pkg::ST_LOAD: begin
        d.overcurrent_threshold       = q.overcurrent_threshold_setting & 8'h0F;
        d.overcurrent_delay           = q.overcurrent_delay_setting & 8'h0F;
        d.short_circuit_discharge_cfg = q.short_circuit_setting & 8'hF7;
        d.st                          = dfp_pkg::ST_RUN;
      end
      dfp_pkg::ST_RUN: begin
        d.st = dfp_pkg::ST_RUN;
      end
      default: begin
        d.st = dfp_pkg::ST_CLEAR;
      end
    endcase

    // Qualification counters restart on any drop of the indication
    // restart on drop
    if (oc_over) begin
      if (q.oc_cnt < oc_target) begin
        d.oc_cnt = q.oc_cnt + dfp_pkg::CNT_W'(1);
      end
    end else begin
      d.oc_cnt = '0;
    end
    if (sc_over) begin
      if (q.sc_cnt < sc_target) begin
        d.sc_cnt = q.sc_cnt + dfp_pkg::CNT_W'(1);
      end
    end else begin
      d.sc_cnt = '0;
    end
    // Held flags stop one long fault from firing again each cycle
    d.oc_held = oc_over && (q.oc_held || oc_trip);
    d.sc_held = sc_over && (q.sc_held || sc_trip);

    // Register writes
    if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        dfp_pkg::ADDR_OC_THRESH: begin
          d.overcurrent_threshold = {4'h0, reg_req_in.wdata[dfp_pkg::CODE_MSB:0]};
        end
        dfp_pkg::ADDR_OC_DELAY: begin
          d.overcurrent_delay = {4'h0, reg_req_in.wdata[dfp_pkg::CODE_MSB:0]};
        end
        dfp_pkg::ADDR_SC_CFG: begin
          d.short_circuit_discharge_cfg = reg_req_in.wdata & 8'hF7;
        end
        dfp_pkg::ADDR_OC_TH_SET: begin
          if (reg_req_in.wdata > dfp_pkg::OC_TH_SET_MAX) begin
            d.overcurrent_threshold_setting = dfp_pkg::OC_TH_SET_MAX;
          end else begin
            d.overcurrent_threshold_setting = reg_req_in.wdata;
          end
        end
        dfp_pkg::ADDR_OC_DLY_SET: begin
          d.overcurrent_delay_setting = reg_req_in.wdata;
        end
        dfp_pkg::ADDR_SC_SET: begin
          d.short_circuit_setting = reg_req_in.wdata;
        end
        dfp_pkg::ADDR_CONTROL: begin
          d.sense_range_select   = reg_req_in.wdata[dfp_pkg::CTL_RANGE_BIT];
          d.short_delay_doubling = reg_req_in.wdata[dfp_pkg::CTL_DOUBLE_BIT];
          if (reg_req_in.wdata[dfp_pkg::CTL_RELOAD_BIT]) begin
            d.st      = dfp_pkg::ST_CLEAR;
            d.oc_cnt  = '0;
            d.sc_cnt  = '0;
            d.oc_held = 1'b0;
            d.sc_held = 1'b0;
          end
        end
        dfp_pkg::ADDR_MASK: begin
          d.mask = reg_req_in.wdata[1:0];
        end
        default: begin
          d.mask = q.mask;
        end
      endcase
    end

    // Sticky status: a trip in the clearing cycle survives the clear
    // separate sticky flags
    d.status = (q.status & ~evt_clr) | evt_set;

    // Read data stands in the cycle after the strobe only
    d.rdata = '0;
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        dfp_pkg::ADDR_OC_THRESH:  d.rdata = q.overcurrent_threshold;
        dfp_pkg::ADDR_OC_DELAY:   d.rdata = q.overcurrent_delay;
        dfp_pkg::ADDR_SC_CFG:     d.rdata = q.short_circuit_discharge_cfg;
        dfp_pkg::ADDR_OC_TH_SET:  d.rdata = q.overcurrent_threshold_setting;
        dfp_pkg::ADDR_OC_DLY_SET: d.rdata = q.overcurrent_delay_setting;
        dfp_pkg::ADDR_SC_SET:     d.rdata = q.short_circuit_setting;
        dfp_pkg::ADDR_CONTROL:    d.rdata = {6'h00, q.short_delay_doubling, q.sense_range_select};
        dfp_pkg::ADDR_STATUS:     d.rdata = {6'h00, q.status};
        dfp_pkg::ADDR_MASK:       d.rdata = {6'h00, q.mask};
        dfp_pkg::ADDR_LIVE:       d.rdata = {5'h00, (q.st != dfp_pkg::ST_RUN), sc_over, oc_over};
        default:                  d.rdata = '0;
      endcase
    end

    // Outputs: interrupt level and fault pulses, all registered
    d.irq      = |(d.status & d.mask);
    d.oc_fault = oc_trip;
    d.sc_fault = sc_trip;
  end

  // State register; settings reset to their stored defaults
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q.st                            <= dfp_pkg::ST_CLEAR;
      q.overcurrent_threshold         <= dfp_pkg::ACTIVE_RESET;
      q.overcurrent_delay             <= dfp_pkg::ACTIVE_RESET;
      q.short_circuit_discharge_cfg   <= dfp_pkg::ACTIVE_RESET;
      q.overcurrent_threshold_setting <= dfp_pkg::OC_TH_SET_RESET;
      q.overcurrent_delay_setting     <= dfp_pkg::OC_DLY_SET_RESET;
      q.short_circuit_setting         <= dfp_pkg::SC_SET_RESET;
      q.sense_range_select            <= 1'b0;
      q.short_delay_doubling          <= 1'b0;
      q.status                        <= 2'b00;
      q.mask                          <= 2'b00;
      q.oc_cnt                        <= '0;
      q.sc_cnt                        <= '0;
      q.oc_held                       <= 1'b0;
      q.sc_held                       <= 1'b0;
      q.rdata                         <= '0;
      q.irq                           <= 1'b0;
      q.oc_fault                      <= 1'b0;
      q.sc_fault                      <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_out = q.rdata;
  assign irq_out       = q.irq;
  assign oc_fault_out  = q.oc_fault;
  assign sc_fault_out  = q.sc_fault;

endmodule

// file: dfp_pkg.sv
// Constants, field layout and carrier types of the discharge fault protection block
package dfp_pkg;

  // Bus and datapath widths
  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 8;
  localparam int SENSE_W = 12;
  localparam int THR_W   = 10;
  localparam int CNT_W   = 32;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_OC_THRESH  = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_OC_DELAY   = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_SC_CFG     = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_OC_TH_SET  = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_OC_DLY_SET = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_SC_SET     = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL    = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_MASK       = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_LIVE       = 4'h9;

  // Reset values
  localparam logic [7:0] ACTIVE_RESET     = 8'h00;
  localparam logic [7:0] OC_TH_SET_RESET  = 8'h0F;
  localparam logic [7:0] OC_DLY_SET_RESET = 8'h0F;
  localparam logic [7:0] SC_SET_RESET     = 8'h0F;
  localparam logic [7:0] OC_TH_SET_MAX    = 8'h0F;

  // Field positions
  localparam int CTL_RANGE_BIT  = 0;
  localparam int CTL_DOUBLE_BIT = 1;
  localparam int CTL_RELOAD_BIT = 7;
  localparam int EVT_OC_BIT     = 0;
  localparam int EVT_SC_BIT     = 1;
  localparam int LIVE_BUSY_BIT  = 2;
  localparam int SC_DLY_LSB     = 4;
  localparam int SC_DLY_MSB     = 7;
  localparam int SC_THR_MSB     = 2;
  localparam int CODE_MSB       = 3;

  // Thresholds in mV
  localparam int OC_THR_BASE_MV     = 50;
  localparam int OC_THR_STEP_MV     = 10;
  localparam int OC_THR_BASE_LO_MV  = 25;
  localparam int OC_THR_STEP_LO_MV  = 5;
  localparam int SC_THR_BASE_MV     = 100;
  localparam int SC_THR_STEP_MV     = 50;
  localparam int SC_THR_BASE_LO_MV  = 50;
  localparam int SC_THR_STEP_LO_MV  = 25;

  // Delays in ms, and the clock rate they are counted at
  localparam int CLK_HZ            = 10_000_000;
  localparam int OC_DLY_BASE_MS    = 1;
  localparam int OC_DLY_STEP_MS    = 2;
  localparam int SC_DLY_STEP_MS    = 61;
  localparam int MS_CYCLES         = CLK_HZ / 1000;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_s;

  // Differential sense pair, mV codes
  typedef struct packed {
    logic [SENSE_W-1:0] sense_positive;
    logic [SENSE_W-1:0] sense_negative;
  } sense_pair_s;

  typedef enum logic [1:0] {ST_CLEAR, ST_LOAD, ST_RUN} load_state_e;

  // Whole state of the block
  typedef struct packed {
    load_state_e       st;
    logic [7:0]        overcurrent_threshold;
    logic [7:0]        overcurrent_delay;
    logic [7:0]        short_circuit_discharge_cfg;
    logic [7:0]        overcurrent_threshold_setting;
    logic [7:0]        overcurrent_delay_setting;
    logic [7:0]        short_circuit_setting;
    logic              sense_range_select;
    logic              short_delay_doubling;
    logic [1:0]        status;
    logic [1:0]        mask;
    logic [CNT_W-1:0]  oc_cnt;
    logic [CNT_W-1:0]  sc_cnt;
    logic              oc_held;
    logic              sc_held;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              oc_fault;
    logic              sc_fault;
  } dfp_state_s;

endpackage

// file: dfp_chk.sv
// Assertion checker for the discharge fault protection block
module dfp_chk #(
  parameter int MS_CYCLES_P = dfp_pkg::MS_CYCLES
) (
  input  wire logic                         sys_clk_in,
  input  wire logic                         rst_n_in,
  input  wire dfp_pkg::reg_req_s            reg_req_in,
  input  wire dfp_pkg::sense_pair_s         sense_in,
  input  wire logic [dfp_pkg::DATA_W-1:0]   reg_rdata_out,
  input  wire logic                         irq_out,
  input  wire logic                         oc_fault_out,
  input  wire logic                         sc_fault_out
);
  logic signed [12:0] diff;
  logic [31:0]        oc_run_q;
  logic [31:0]        sc_run_q;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Differential sense, discharge positive
  assign diff = $signed({1'b0, sense_in.sense_positive}) - $signed({1'b0, sense_in.sense_negative});

  // Runs above the lowest thresholds any code can select
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      oc_run_q <= '0;
      sc_run_q <= '0;
    end else begin
      oc_run_q <= (diff >= 13'sd25) ? oc_run_q + 32'd1 : '0;
      sc_run_q <= (diff >= 13'sd50) ? sc_run_q + 32'd1 : '0;
    end
  end

  oc_thr_upper_a: assert property (reg_req_in.rd && reg_req_in.addr == dfp_pkg::ADDR_OC_THRESH
    |=> reg_rdata_out[7:4] == 4'h0) else $error("threshold upper bits not zero");
  oc_dly_upper_a: assert property (reg_req_in.rd && reg_req_in.addr == dfp_pkg::ADDR_OC_DELAY
    |=> reg_rdata_out[7:4] == 4'h0) else $error("delay upper bits not zero");
  sc_bit3_a: assert property (reg_req_in.rd && reg_req_in.addr == dfp_pkg::ADDR_SC_CFG
    |=> !reg_rdata_out[3]) else $error("short-circuit bit 3 set");
  setting_limit_a: assert property (reg_req_in.rd && reg_req_in.addr == dfp_pkg::ADDR_OC_TH_SET
    |=> reg_rdata_out <= 8'h0F) else $error("threshold setting above limit");
  oc_qualify_a: assert property (oc_fault_out |-> oc_run_q >= MS_CYCLES_P)
    else $error("overcurrent fault before its delay");
  sc_qualify_a: assert property (sc_fault_out |-> sc_run_q >= 32'd1)
    else $error("short-circuit fault below threshold");
  fault_pulse_a: assert property (oc_fault_out || sc_fault_out
    |=> !oc_fault_out && !sc_fault_out) else $error("fault pulse longer than one cycle");
  irq_mask_a: assert property (reg_req_in.wr && reg_req_in.addr == dfp_pkg::ADDR_MASK
    && reg_req_in.wdata == 8'h00 |=> !irq_out) else $error("interrupt high while masked");
  reload_quiet_a: assert property (reg_req_in.wr && reg_req_in.addr == dfp_pkg::ADDR_CONTROL
    && reg_req_in.wdata[7] |=> ##1 !oc_fault_out && !sc_fault_out) else $error("fault during reload");
endmodule

bind discharge_fault_protection_config dfp_chk #(.MS_CYCLES_P(MS_CYCLES_P)) u_chk (
  .sys_clk_in    (sys_clk_in),
  .rst_n_in      (rst_n_in),
  .reg_req_in    (reg_req_in),
  .sense_in      (sense_in),
  .reg_rdata_out (reg_rdata_out),
  .irq_out       (irq_out),
  .oc_fault_out  (oc_fault_out),
  .sc_fault_out  (sc_fault_out)
);

// file: sense_model.sv
// Behavioural model of the sense resistor pair
module sense_model (
  input  wire logic signed [12:0] diff_mv_in,
  output dfp_pkg::sense_pair_s    sense_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Common level keeps both nodes positive, so negative drops still encode
  localparam logic [11:0] COMMON_MV = 12'h0200;
  assign sense_out = '{sense_positive: COMMON_MV + diff_mv_in[11:0], sense_negative: COMMON_MV};
endmodule

// file: testbench.sv
// Self-checking testbench for the discharge fault protection block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 4;
  logic                 sys_clk_in = 1'b0;
  logic                 rst_n_in = 1'b0;
  dfp_pkg::reg_req_s    req = '0;
  logic signed [12:0]   diff_mv = '0;
  dfp_pkg::sense_pair_s sense;
  logic [7:0]           rdata;
  logic                 irq;
  logic                 oc_fault;
  logic                 sc_fault;
  logic                 rd_seen = 1'b0;
  logic [7:0]           exp_q[$];
  logic [7:0]           v = 8'h2F; // LFSR seed, 47
  logic [7:0]           s;
  // Active values expected until the next reload
  logic [7:0]           oc_exp = 8'h0F;
  logic [7:0]           sc_exp = 8'h07;
  int                   n_mismatch = 0;
  int                   tests_run = 0;
  int                   n_oc = 0;
  int                   n_sc = 0;
  int                   e_oc = 0;
  int                   e_sc = 0;
  int                   cycles = 0;
  int                   th;

  sense_model u_sense (.diff_mv_in(diff_mv), .sense_out(sense));
  discharge_fault_protection_config #(.MS_CYCLES_P(MS)) u_dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_req_in(req), .sense_in(sense),
    .reg_rdata_out(rdata), .irq_out(irq), .oc_fault_out(oc_fault), .sc_fault_out(sc_fault));

  always #50 sys_clk_in = ~sys_clk_in;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    req <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge sys_clk_in);
    req <= '0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic run(input int mv, input int n);
    diff_mv <= 13'(mv);
    repeat (n) @(posedge sys_clk_in);
  endtask
  // Hold a level, drop it, then read and clear the sticky flags
  task automatic trip(input int mv, input int n, input logic [7:0] e);
    run(mv, n);
    run(0, 2);
    e_oc += int'(e[0]);
    e_sc += int'(e[1]);
    // One pulse per qualified fault, however long the level stays
    check({4'(n_sc), 4'(n_oc)}, {4'(e_sc), 4'(e_oc)});
    rd(dfp_pkg::ADDR_STATUS, e);
    wr(dfp_pkg::ADDR_STATUS, 8'h03);
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    check({7'h00, irq}, {7'h00, e});
  endtask
  task automatic complete_run();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Note read strobes and bound the run
  always @(posedge sys_clk_in) begin
    rd_seen <= req.rd;
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // Read data stands only in the cycle after the strobe; fault pulses counted
  always @(negedge sys_clk_in) begin
    if (oc_fault) begin
      n_oc++;
    end
    if (sc_fault) begin
      n_sc++;
    end
    if (rd_seen) begin
      check(rdata, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    // Active registers still read zero while the load is under way
    rd(dfp_pkg::ADDR_OC_THRESH, 8'h00);
    rd(dfp_pkg::ADDR_OC_THRESH, 8'h0F);
    rd(dfp_pkg::ADDR_OC_DELAY, 8'h0F);
    rd(dfp_pkg::ADDR_SC_CFG, 8'h07);
    // Random settings land only after a full reload
    repeat (4) begin
      v = lfsr(v);
      s = v >> 3;
      wr(dfp_pkg::ADDR_OC_TH_SET, s);
      wr(dfp_pkg::ADDR_OC_DLY_SET, v);
      wr(dfp_pkg::ADDR_SC_SET, v);
      rd(dfp_pkg::ADDR_OC_TH_SET, (s > 8'h0F) ? 8'h0F : s);
      rd(dfp_pkg::ADDR_OC_THRESH, oc_exp);
      rd(dfp_pkg::ADDR_SC_CFG, sc_exp);
      wr(dfp_pkg::ADDR_CONTROL, 8'h80);
      rd(dfp_pkg::ADDR_LIVE, 8'h04);
      oc_exp = (s > 8'h0F) ? 8'h0F : s;
      sc_exp = v & 8'hF7;
      rd(dfp_pkg::ADDR_OC_THRESH, oc_exp);
      rd(dfp_pkg::ADDR_OC_DELAY, v & 8'h0F);
      rd(dfp_pkg::ADDR_SC_CFG, sc_exp);
    end
    wr(dfp_pkg::ADDR_OC_THRESH, 8'hF0);
    rd(dfp_pkg::ADDR_OC_THRESH, 8'h00);
    wr(dfp_pkg::ADDR_OC_DELAY, 8'hF0);
    rd(dfp_pkg::ADDR_OC_DELAY, 8'h00);
    wr(dfp_pkg::ADDR_SC_CFG, 8'h0F);
    rd(dfp_pkg::ADDR_SC_CFG, 8'h07);
    rd(4'hF, 8'h00);
    wr(dfp_pkg::ADDR_MASK, 8'h03);
    rd(dfp_pkg::ADDR_MASK, 8'h03);
    wr(dfp_pkg::ADDR_STATUS, 8'h03);
    // Threshold edges for both sense ranges, lowest and highest code
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 16; c += 15) begin
        wr(dfp_pkg::ADDR_CONTROL, 8'(r));
        wr(dfp_pkg::ADDR_OC_THRESH, 8'(c));
        th = (r != 0) ? 25 + 5 * c : 50 + 10 * c;
        trip(th - 1, 12, 8'h00);
        trip(th, 12, 8'h01);
      end
    end
    // A drop restarts the 3 ms count; code 0 puts 60 mV above the 50 mV threshold
    wr(dfp_pkg::ADDR_CONTROL, 8'h00);
    wr(dfp_pkg::ADDR_OC_THRESH, 8'h00);
    wr(dfp_pkg::ADDR_OC_DELAY, 8'h01);
    run(60, 10);
    trip(0, 1, 8'h00);
    trip(60, 10, 8'h00);
    trip(60, 16, 8'h01);
    // Short circuit at 0 ms, with interrupt masking
    wr(dfp_pkg::ADDR_OC_THRESH, 8'h0F);
    wr(dfp_pkg::ADDR_SC_CFG, 8'h00);
    trip(99, 6, 8'h00);
    run(100, 2);
    run(0, 2);
    irq_is(1'b1);
    wr(dfp_pkg::ADDR_MASK, 8'h00);
    irq_is(1'b0);
    wr(dfp_pkg::ADDR_MASK, 8'h03);
    trip(0, 1, 8'h02);
    irq_is(1'b0);
    wr(dfp_pkg::ADDR_CONTROL, 8'h01);
    trip(50, 2, 8'h02);
    // One 61 ms step, plain and doubled
    wr(dfp_pkg::ADDR_CONTROL, 8'h00);
    wr(dfp_pkg::ADDR_SC_CFG, 8'h10);
    trip(120, 230, 8'h00);
    trip(120, 260, 8'h02);
    wr(dfp_pkg::ADDR_CONTROL, 8'h02);
    rd(dfp_pkg::ADDR_CONTROL, 8'h02);
    trip(120, 300, 8'h00);
    trip(120, 500, 8'h02);
    repeat (3) @(posedge sys_clk_in);
    complete_run();
  end
endmodule
